// ==== inc/brtl_pkg.sv ====
// constants and types shared by the button and rotary trigger logic
package brtl_pkg;

  // ************************************************************
  // register map, byte addresses on the register bus
  // ************************************************************
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_MODE_LO  = 12'h004;
  localparam logic [11:0] OFF_MODE_HI  = 12'h008;
  localparam logic [11:0] OFF_STATE    = 12'h00C;
  localparam logic [11:0] OFF_VOLUME   = 12'h010;
  localparam logic [11:0] OFF_CMD_MAP  = 12'h014;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h01C;

  // ************************************************************
  // control and volume field positions
  // ************************************************************
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_CUSTOM  = 1;
  localparam int VOL_MUTE_BIT = 8;

  // ************************************************************
  // buttons and behaviour codes
  // ************************************************************
  localparam int         NUM_BTN   = 11;
  localparam int         NUM_GRP   = 5;
  localparam int         MODE_W    = 3;
  localparam int         MODE_ALL  = NUM_BTN * MODE_W;
  localparam int         LO_BTNS   = 8;
  localparam logic [2:0] MODE_MOM  = 3'h0;
  localparam logic [2:0] MODE_TOG  = 3'h1;
  localparam logic [2:0] MODE_RAD1 = 3'h2;
  localparam logic [2:0] MODE_RAD5 = 3'h6;

  // ************************************************************
  // rotary position range
  // ************************************************************
  localparam int         POS_W   = 5;
  localparam int         NUM_POS = 17;
  localparam logic [4:0] POS_MIN = 5'h00;
  localparam logic [4:0] POS_MAX = 5'h10;

  // ************************************************************
  // interrupt status bits
  // ************************************************************
  localparam int IRQ_W      = 5;
  localparam int IRQ_BTN    = 0;
  localparam int IRQ_VOL    = 1;
  localparam int IRQ_KPRESS = 2;
  localparam int IRQ_KREL   = 3;
  localparam int IRQ_MUTE   = 4;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [1:0]  RST_CTRL    = 2'h1;
  localparam logic [32:0] RST_MODE    = 33'h000000000;
  localparam logic [16:0] RST_CMD_MAP = 17'h00000;
  localparam logic [4:0]  RST_MASK    = 5'h00;
  localparam logic [4:0]  RST_POS     = 5'h00;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ     = 40;
  localparam int DB_TICK_US  = 1000;
  localparam int DB_TICK_CYC = DB_TICK_US * CLK_MHZ;
  localparam int DB_STABLE   = 4;
  localparam int TICK_W      = 16;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic [NUM_BTN-1:0] btn;
    logic               knob;
    logic               rot_a;
    logic               rot_b;
  } brtl_pins_s;

  localparam int PINS_W = NUM_BTN + 3;

  typedef struct packed {
    logic             mute;
    logic [POS_W-1:0] pos;
  } brtl_vol_s;

endpackage

// ==== design/brtl_debounce.sv ====
// synchroniser and tick-based debouncer for the contact inputs
`timescale 1ns/1ps
`default_nettype none

module brtl_debounce #(
  parameter int WIDTH = brtl_pkg::PINS_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             tick,
  input  wire logic [WIDTH-1:0] raw_i,
  output logic      [WIDTH-1:0] clean_o
);

  logic [WIDTH-1:0] sync1_r;
  logic [WIDTH-1:0] sync2_r;
  logic [2:0]       cnt_r [WIDTH];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_i;
      sync2_r <= sync1_r;
    end
  end

  // accept a level only once stable for several ticks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clean_o <= '0;
      for (int i = 0; i < WIDTH; i++) cnt_r[i] <= 3'h0;
    end else if (tick) begin
      for (int i = 0; i < WIDTH; i++) begin
        if (sync2_r[i] == clean_o[i]) begin
          cnt_r[i] <= 3'h0;
        end else if (cnt_r[i] == 3'(brtl_pkg::DB_STABLE - 1)) begin
          cnt_r[i]   <= 3'h0;
          clean_o[i] <= sync2_r[i];
        end else begin
          cnt_r[i] <= cnt_r[i] + 3'h1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// ==== design/brtl_top.sv ====
// button and rotary trigger logic with its register slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - eleven buttons, each pressed or released, each with own state
// - each button selects momentary, toggle or one numbered radio group
// - momentary: state true while pressed, false on release
// - toggle: each press inverts state; release leaves it
// - radio: press sets own state, clears other group members
// - five radio groups; one group per button, up to eleven members
// - every button state is presented as an output
// - rotary position kept within zero to sixteen inclusive
// - reaching a position with a command assigned signals the action
// - custom scheme: knob press and release reported as events instead
module brtl_top #(
  parameter int TICK_CYC = brtl_pkg::DB_TICK_CYC
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [brtl_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire logic [brtl_pkg::NUM_BTN-1:0] btn_i,
  input  wire logic                         knob_i,
  input  wire logic                         rot_a_i,
  input  wire logic                         rot_b_i,
  output logic      [brtl_pkg::NUM_BTN-1:0] btn_state_o,
  output brtl_pkg::brtl_vol_s               vol_o,
  output logic                              vol_hit_o,
  output logic                              knob_press_o,
  output logic                              knob_release_o,
  output logic                              irq_o
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [2:0] mode_of(
    input logic [brtl_pkg::MODE_ALL-1:0] modes,
    input int                            idx
  );
    mode_of = modes[idx*brtl_pkg::MODE_W +: brtl_pkg::MODE_W];
  endfunction

  function automatic logic is_radio(input logic [2:0] m);
    is_radio = (m >= brtl_pkg::MODE_RAD1) && (m <= brtl_pkg::MODE_RAD5);
  endfunction

  function automatic logic [31:0] word(input logic [brtl_pkg::ADDR_W-1:0] a,
                                      input logic [brtl_pkg::ADDR_W-1:0] o);
    word = {31'h00000000, a == o};
  endfunction

  // ************************************************************
  // declarations
  // ************************************************************
  logic [brtl_pkg::TICK_W-1:0]   tick_cnt_r;
  logic                          tick_r;
  brtl_pkg::brtl_pins_s          raw;
  brtl_pkg::brtl_pins_s          clean;
  brtl_pkg::brtl_pins_s          clean_d_r;
  logic [1:0]                    ctrl_r;
  logic [brtl_pkg::MODE_ALL-1:0] mode_r;
  logic [brtl_pkg::NUM_POS-1:0]  cmd_map_r;
  logic [brtl_pkg::IRQ_W-1:0]    stat_r;
  logic [brtl_pkg::IRQ_W-1:0]    stat_nxt;
  logic [brtl_pkg::IRQ_W-1:0]    mask_r;
  logic [brtl_pkg::IRQ_W-1:0]    ev_set;
  logic [brtl_pkg::NUM_BTN-1:0]  state_nxt;
  logic [brtl_pkg::NUM_BTN-1:0]  press;
  logic [brtl_pkg::NUM_BTN-1:0]  release_ev;
  logic                          knob_rise;
  logic                          knob_fall;
  logic                          step_right;
  logic                          step_left;
  logic [brtl_pkg::POS_W-1:0]    pos_nxt;
  logic                          mute_nxt;
  logic                          enabled;
  logic                          custom;
  logic                          setup;
  logic                          access;
  logic                          wr;
  logic                          rd_stat;
  logic [31:0]                   rdata;
  logic                          hit;

  assign enabled = ctrl_r[brtl_pkg::CTRL_ENABLE];
  assign custom  = ctrl_r[brtl_pkg::CTRL_CUSTOM];

  // ************************************************************
  // debounce tick divider
  // ************************************************************
  // one-cycle enable; the debouncer counts ticks, not clocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == brtl_pkg::TICK_W'(TICK_CYC - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  // ************************************************************
  // contact conditioning and edge detection
  // ************************************************************
  assign raw.btn   = btn_i;
  assign raw.knob  = knob_i;
  assign raw.rot_a = rot_a_i;
  assign raw.rot_b = rot_b_i;

  brtl_debounce #(
    .WIDTH (brtl_pkg::PINS_W)
  ) u_debounce (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick_r),
    .raw_i   (raw),
    .clean_o (clean)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clean_d_r <= '0;
    end else begin
      clean_d_r <= clean;
    end
  end

  // clean levels reset to released, so no false edge after reset
  // press and release edges of the clean levels
  assign press      = clean.btn & ~clean_d_r.btn & {brtl_pkg::NUM_BTN{enabled}};
  assign release_ev = ~clean.btn & clean_d_r.btn & {brtl_pkg::NUM_BTN{enabled}};
  assign knob_rise  = clean.knob & ~clean_d_r.knob & enabled;
  assign knob_fall  = ~clean.knob & clean_d_r.knob & enabled;
  // one detent per rising edge of phase a; phase b gives direction
  assign step_right = clean.rot_a & ~clean_d_r.rot_a & ~clean.rot_b & enabled;
  assign step_left  = clean.rot_a & ~clean_d_r.rot_a & clean.rot_b & enabled;

  // ************************************************************
  // button interaction states
  // ************************************************************
  always_comb begin
    state_nxt = btn_state_o;
    for (int i = 0; i < brtl_pkg::NUM_BTN; i++) begin
      // behaviour picked by the mode field
      case (mode_of(mode_r, i))
        brtl_pkg::MODE_TOG: begin
          if (press[i]) begin
            state_nxt[i] = ~btn_state_o[i];
          end
        end
        brtl_pkg::MODE_MOM: begin
          if (press[i]) begin
            state_nxt[i] = 1'b1;
          end else if (release_ev[i]) begin
            state_nxt[i] = 1'b0;
          end
        end
        default: begin
          // codes above the fifth group behave as momentary
          if (!is_radio(mode_of(mode_r, i))) begin
            if (press[i]) begin
              state_nxt[i] = 1'b1;
            end else if (release_ev[i]) begin
              state_nxt[i] = 1'b0;
            end
          end
        end
      endcase
    end
    // radio press wins the group; on simultaneous presses
    // the lowest index is applied last and so prevails
    // a group is all buttons sharing one radio code
    for (int i = brtl_pkg::NUM_BTN - 1; i >= 0; i--) begin
      if (press[i] && is_radio(mode_of(mode_r, i))) begin
        for (int j = 0; j < brtl_pkg::NUM_BTN; j++) begin
          if (mode_of(mode_r, j) == mode_of(mode_r, i)) begin
            state_nxt[j] = (j == i);
          end
        end
      end
    end
  end

  // states are presented straight from flip-flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      btn_state_o <= '0;
    end else begin
      btn_state_o <= state_nxt;
    end
  end

  // ************************************************************
  // rotary position and mute
  // ************************************************************
  always_comb begin
    pos_nxt = vol_o.pos;
    if (step_right && vol_o.pos != brtl_pkg::POS_MAX) begin
      pos_nxt = vol_o.pos + 5'h01;
    end else if (step_left && vol_o.pos != brtl_pkg::POS_MIN) begin
      pos_nxt = vol_o.pos - 5'h01;
    end
  end

  assign mute_nxt = (knob_rise && !custom) ? ~vol_o.mute : vol_o.mute;

  // saturation is silent: no hit and no status at the limits
  // action only when the position actually arrives
  assign hit = (pos_nxt != vol_o.pos) && cmd_map_r[pos_nxt];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vol_o.pos  <= brtl_pkg::RST_POS;
      vol_o.mute <= 1'b0;
      vol_hit_o  <= 1'b0;
    end else begin
      vol_o.pos  <= pos_nxt;
      vol_o.mute <= mute_nxt;
      vol_hit_o  <= hit;
    end
  end

  // knob events reported only in the custom scheme
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      knob_press_o   <= 1'b0;
      knob_release_o <= 1'b0;
    end else begin
      knob_press_o   <= knob_rise & custom;
      knob_release_o <= knob_fall & custom;
    end
  end

  // ************************************************************
  // register slave
  // ************************************************************
  // pready rises one cycle after setup, so every transfer completes in its first access cycle with no wait
  assign setup   = psel & ~penable;
  assign access  = psel & penable & pready;
  assign wr      = access & pwrite;
  assign rd_stat = access & ~pwrite & (paddr == brtl_pkg::OFF_IRQ_STAT);

  always_comb begin
    rdata = 32'h00000000;
    case (paddr)
      brtl_pkg::OFF_CTRL:     rdata = {30'h00000000, ctrl_r};
      brtl_pkg::OFF_MODE_LO:  rdata = {8'h00, mode_r[23:0]};
      brtl_pkg::OFF_MODE_HI:  rdata = {23'h000000, mode_r[32:24]};
      brtl_pkg::OFF_STATE:    rdata = {21'h000000, btn_state_o};
      brtl_pkg::OFF_VOLUME:   rdata = {23'h000000, vol_o.mute,
                                       3'h0, vol_o.pos};
      brtl_pkg::OFF_CMD_MAP:  rdata = {15'h0000, cmd_map_r};
      brtl_pkg::OFF_IRQ_STAT: rdata = {27'h0000000, stat_r};
      brtl_pkg::OFF_IRQ_MASK: rdata = {27'h0000000, mask_r};
      default:                rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & (paddr[1:0] != 2'h0 || paddr > brtl_pkg::OFF_IRQ_MASK);
      // sampled at setup so the word stands through the access cycle
      if (setup && !pwrite) begin
        prdata <= rdata;
      end
    end
  end

  // configuration writes; read-only words drop writes silently
  // an unmapped word is refused by pslverr and changes nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r    <= brtl_pkg::RST_CTRL;
      mode_r    <= brtl_pkg::RST_MODE;
      cmd_map_r <= brtl_pkg::RST_CMD_MAP;
      mask_r    <= brtl_pkg::RST_MASK;
    end else if (wr) begin
      case (paddr)
        brtl_pkg::OFF_CTRL:     ctrl_r          <= pwdata[1:0];
        brtl_pkg::OFF_MODE_LO:  mode_r[23:0]    <= pwdata[23:0];
        brtl_pkg::OFF_MODE_HI:  mode_r[32:24]   <= pwdata[8:0];
        brtl_pkg::OFF_CMD_MAP:  cmd_map_r       <= pwdata[16:0];
        brtl_pkg::OFF_IRQ_MASK: mask_r          <= pwdata[4:0];
        default:                ctrl_r          <= ctrl_r;
      endcase
    end
  end

  // ************************************************************
  // interrupt status
  // ************************************************************
  // one bit per event source; masked bits still record
  always_comb begin
    ev_set                       = '0;
    ev_set[brtl_pkg::IRQ_BTN]    = (state_nxt != btn_state_o);
    ev_set[brtl_pkg::IRQ_VOL]    = hit;
    ev_set[brtl_pkg::IRQ_KPRESS] = knob_rise & custom;
    ev_set[brtl_pkg::IRQ_KREL]   = knob_fall & custom;
    ev_set[brtl_pkg::IRQ_MUTE]   = mute_nxt != vol_o.mute;
  end

  // a read clears only the bits it reported; a bit set while the read
  // was in setup was never seen by software and must survive the clear
  // an event in the clearing cycle itself still lands: set wins
  assign stat_nxt = (rd_stat ? stat_r & ~prdata[brtl_pkg::IRQ_W-1:0]
                             : stat_r) | ev_set;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
      irq_o  <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_o  <= |(stat_nxt & mask_r);
    end
  end

endmodule

`default_nettype wire

// ==== verif/brtl_top_monitor.sv ====
// concurrent checks on the ports of the trigger block
`timescale 1ns/1ps
`default_nettype none

module brtl_top_monitor (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire brtl_pkg::brtl_vol_s vol_o,
  input wire logic                vol_hit_o,
  input wire logic                knob_press_o,
  input wire logic                knob_release_o,
  input wire logic                irq_o
);
  // ************************************************************
  // bus phases and output relations
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence

  a_ready_next: assert property (s_setup |=> s_done)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (s_setup ##0
    (paddr > 12'h01C || paddr[1:0] != 2'h0) |=> pslverr)
    else $error("no error on unmapped address");
  // irq is registered one cycle after the mask lands
  a_mask_quiet: assert property (s_done ##0 (pwrite &&
    paddr == 12'h01C && pwdata[4:0] == 5'h00) |-> ##2 !irq_o)
    else $error("interrupt high with all masked");
  a_pos_range: assert property (vol_o.pos <= 5'h10)
    else $error("position beyond sixteen");
  a_pos_step: assert property ($changed(vol_o.pos) |->
    vol_o.pos == $past(vol_o.pos) + 5'h01 ||
    vol_o.pos == $past(vol_o.pos) - 5'h01)
    else $error("position moved by more than one");
  a_hit_move: assert property (vol_hit_o |-> $changed(vol_o.pos))
    else $error("hit without movement");
  a_knob_mute: assert property ((knob_press_o || knob_release_o) |->
    $stable(vol_o.mute))
    else $error("mute moved in custom scheme");
  a_knob_pulse: assert property (knob_press_o |=> !knob_press_o)
    else $error("knob press pulse too long");
endmodule

bind brtl_top brtl_top_monitor i_mon (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .vol_o(vol_o), .vol_hit_o(vol_hit_o), .knob_press_o(knob_press_o),
  .knob_release_o(knob_release_o), .irq_o(irq_o));

`default_nettype wire

// ==== verif/brtl_panel_model.sv ====
// user at the panel: chattering push contacts and a detented knob
`timescale 1ns/1ps
`default_nettype none

module brtl_panel_model #(
  parameter int HOLD = 40
) (
  input  wire logic            clk,
  output brtl_pkg::brtl_pins_s pins_o
);
  // ************************************************************
  // contact levels
  // ************************************************************
  logic [brtl_pkg::PINS_W-1:0] c_r = '0;
  assign pins_o = c_r;

  // real contacts chatter for a few clocks before they settle
  task automatic drive(input int i, input logic v);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      c_r[i] <= k[0] ? ~v : v;
    end
    repeat (HOLD) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the button and rotary trigger block
`timescale 1ns/1ps
`default_nettype none

module testbench;
  // ************************************************************
  // signals and bookkeeping
  // ************************************************************
  logic                 clk, rst, psel, penable, pwrite, pready, pslverr;
  logic                 hit, kp, kr, irq, em;
  logic [11:0]          paddr;
  logic [31:0]          pwdata, prdata, rnd;
  logic [10:0]          st, st_d, e;
  logic [4:0]           ep;
  brtl_pkg::brtl_pins_s pins;
  brtl_pkg::brtl_vol_s  vol, vol_d;
  logic [32:0]          rd_q[$];
  logic [10:0]          st_q[$];
  brtl_pkg::brtl_vol_s  vol_q[$];
  int                   fail_count = 0, n_tests = 0, kp_n = 0, kr_n = 0;
  int                   hit_n = 0;
  localparam int RB = 0, RA = 1, KNOB = 2;

  brtl_top #(.TICK_CYC(4)) i_dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .btn_i(pins.btn), .knob_i(pins.knob),
    .rot_a_i(pins.rot_a), .rot_b_i(pins.rot_b), .btn_state_o(st),
    .vol_o(vol), .vol_hit_o(hit), .knob_press_o(kp),
    .knob_release_o(kr), .irq_o(irq));
  brtl_panel_model i_panel (.clk(clk), .pins_o(pins));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ************************************************************
  // tasks
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic cmp(input logic [32:0] g, input logic [32:0] x,
                     input string m);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) cmp(1'b0, 1'b1, "no ready");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic er);
    rd_q.push_back({er, x});
    apb(1'b0, a, 32'h0);
  endtask

  task automatic tap(input int i, input logic [10:0] nxt);
    if (nxt !== e) st_q.push_back(nxt);
    e = nxt;
    i_panel.drive(3 + i, 1'b1);
    i_panel.drive(3 + i, 1'b0);
  endtask

  task automatic det(input logic left);
    logic [4:0] np;
    if (left) np = (ep == 5'h00) ? ep : ep - 5'h01;
    else np = (ep == 5'h10) ? ep : ep + 5'h01;
    if (np != ep) vol_q.push_back({em, np});
    ep = np;
    i_panel.drive(RB, left);
    i_panel.drive(RA, 1'b1);
    i_panel.drive(RA, 1'b0);
  endtask

  task automatic knob(input logic tog);
    if (tog) begin
      em = ~em;
      vol_q.push_back({em, ep});
    end
    i_panel.drive(KNOB, 1'b1);
    i_panel.drive(KNOB, 1'b0);
  endtask

  // ************************************************************
  // result watcher: each appearing result takes the oldest note
  // ************************************************************
  always @(posedge clk) begin
    st_d <= st;
    vol_d <= vol;
    if (kp === 1'b1) kp_n++;
    if (kr === 1'b1) kr_n++;
    if (hit === 1'b1) hit_n++;
    if (!rst && st !== st_d) begin
      if (st_q.size() == 0) cmp(1'b1, 1'b0, "stray state change");
      else cmp(st, st_q.pop_front(), "button state");
    end
    if (!rst && vol !== vol_d) begin
      if (vol_q.size() == 0) cmp(1'b1, 1'b0, "stray volume change");
      else cmp(vol, vol_q.pop_front(), "volume");
    end
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rd_q.size() == 0) cmp(1'b1, 1'b0, "stray read");
      else cmp({pslverr, prdata}, rd_q.pop_front(), "read data");
    end
  end

  initial begin
    #1000000;
    fail_count++;
    results();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    e = '0;
    ep = '0;
    em = 1'b0;
    rnd = xs(32'hEB75);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd(brtl_pkg::OFF_CTRL, 32'h1, 1'b0);
    rd(brtl_pkg::OFF_MODE_LO, 32'h0, 1'b0);
    rd(brtl_pkg::OFF_MODE_HI, 32'h0, 1'b0);
    rd(brtl_pkg::OFF_CMD_MAP, 32'h0, 1'b0);
    rd(brtl_pkg::OFF_IRQ_MASK, 32'h0, 1'b0);
    rd(brtl_pkg::OFF_VOLUME, 32'h0, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
    rd(12'h006, 32'h0, 1'b1);
    apb(1'b1, brtl_pkg::OFF_IRQ_MASK, 32'h1);
    // b1 toggle, b2 b3 group 5, b4 group 1, b5 group 2, b7 spare code
    apb(1'b1, brtl_pkg::OFF_MODE_LO, 32'hE1AD88);
    // b8 group 3, b9 group 4, b10 group 5
    apb(1'b1, brtl_pkg::OFF_MODE_HI, 32'h1AC);
    st_q.push_back(11'h001);
    st_q.push_back(11'h000);
    tap(0, 11'h000);
    tap(1, 11'h002);
    tap(1, 11'h000);
    tap(4, e | 11'h010);
    tap(5, e | 11'h020);
    tap(2, e | 11'h004);
    tap(3, (e & ~11'h004) | 11'h008);
    tap(10, (e & ~11'h008) | 11'h400);
    tap(8, e | 11'h100);
    tap(9, e | 11'h200);
    // spare code 7 must act as momentary
    st_q.push_back(e | 11'h080);
    st_q.push_back(e);
    tap(7, e);
    rd(brtl_pkg::OFF_STATE, {21'h0, e}, 1'b0);
    cmp(irq, 1'b1, "irq raised");
    apb(1'b1, brtl_pkg::OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    cmp(irq, 1'b0, "irq masked");
    apb(1'b1, brtl_pkg::OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk);
    cmp(irq, 1'b1, "irq unmasked");
    rd(brtl_pkg::OFF_IRQ_STAT, 32'h1, 1'b0);
    repeat (2) @(posedge clk);
    cmp(irq, 1'b0, "irq cleared");
    // disabled block must ignore the momentary press
    apb(1'b1, brtl_pkg::OFF_CTRL, 32'h0);
    tap(0, e);
    apb(1'b1, brtl_pkg::OFF_CTRL, 32'h1);
    apb(1'b1, brtl_pkg::OFF_CMD_MAP, {15'h0, rnd[16:0]});
    det(1'b1);
    for (int k = 0; k < 17; k++) det(1'b0);
    det(1'b1);
    rd(brtl_pkg::OFF_IRQ_STAT, {30'h0, |rnd[16:1], 1'b0}, 1'b0);
    // arrivals at 1..16 going up, then at 15 again going down
    cmp(hit_n, $countones(rnd[16:1]) + rnd[15], "volume hits");
    knob(1'b1);
    apb(1'b1, brtl_pkg::OFF_CTRL, 32'h3);
    knob(1'b0);
    cmp(kp_n, 1, "knob press events");
    cmp(kr_n, 1, "knob release events");
    rd(brtl_pkg::OFF_IRQ_STAT, 32'h1C, 1'b0);
    rd(brtl_pkg::OFF_VOLUME, 32'h10F, 1'b0);
    repeat (10) @(posedge clk);
    cmp(st_q.size() + vol_q.size() + rd_q.size(), 0, "results missing");
    results();
  end
endmodule

`default_nettype wire
